// ===== inc/cds_pkg.sv
package cds_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CLK_MHZ        = 100;
    localparam int DCS_MIN_MHZ    = 20;
    localparam int DCS_RELOCK_NS  = 1500;
    localparam int DCS_RELOCK_CYC = (DCS_RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RELOCK_LOAD = 8'(DCS_RELOCK_CYC);
    localparam logic [7:0] RELOCK_LAST = 8'h01;
    localparam logic [7:0] CNT8_ZERO   = 8'h00;
    localparam logic [7:0] CNT8_ONE    = 8'h01;
    localparam logic [7:0] CNT8_MAX    = 8'hff;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ALIGN_CTRL_ADDR = 12'h100;
    localparam logic [DATA_W-1:0] ALIGN_CTRL_RST  = 8'h00;
    localparam logic [DATA_W-1:0] ALIGN_WR_MASK   = 8'hfe;
    localparam logic [DATA_W-1:0] RD_ZERO         = 8'h00;
    localparam int ALIGN_ARMED_BIT   = 0;
    localparam int ALIGN_EN_BIT      = 1;
    localparam int ALIGN_ONESHOT_BIT = 2;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] DIV_CNT_ZERO = 3'h0;
    localparam logic [DIV_W-1:0] DIV_CNT_ONE  = 3'h1;
    localparam logic [DIV_W-1:0] DIV_CODE_1   = 3'h0;
    localparam logic [DIV_W-1:0] DIV_CODE_2   = 3'h1;
    localparam logic [DIV_W-1:0] DIV_CODE_4   = 3'h3;
    localparam logic [3:0]       RAW_HI_LEN   = 4'h1;
    localparam logic             CLK_N_PULL_LVL = 1'b0;

    typedef enum logic [1:0] {
        PWR_RUN     = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_DOWN    = 2'b10
    } cds_pwr_t;

    typedef enum logic [1:0] {
        DCS_OFF    = 2'b00,
        DCS_RELOCK = 2'b01,
        DCS_LOCKED = 2'b10
    } cds_dcs_t;

    // Ratios other than 1, 2 and 4 only work with the stabilizer on
    function automatic logic cds_dcs_needed(input logic [DIV_W-1:0] code);
        return !(code == DIV_CODE_1 || code == DIV_CODE_2 || code == DIV_CODE_4);
    endfunction

    // High phase length for a nominal half period, ratio = code + 1
    function automatic logic [3:0] cds_half_len(input logic [DIV_W-1:0] code);
        logic [3:0] r;
        r = {1'b0, code} + 4'h2;
        return r >> 1;
    endfunction

endpackage

// ===== verilog/cds_align_sync.sv
`timescale 1ns/1ps
module cds_align_sync (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic align_in,
    output logic      align_evt
);
    import cds_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic evt;
    } cds_sync_st_t;

    cds_sync_st_t s_r;
    cds_sync_st_t s_nxt;

    // ------------------------------------------------------------
    // Two-stage synchroniser and rising edge detect
    // ------------------------------------------------------------
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = align_in;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
        s_nxt.evt  = s_r.sync & ~s_r.prev;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign align_evt = s_r.evt;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_evt_single;
        @(posedge ref_clk) disable iff (!rst_n)
        align_evt |=> !align_evt;
    endproperty
    a_evt_single: assert property (p_evt_single)
        else $error("alignment event longer than one cycle");

    property p_evt_latency;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(align_in) |-> ##3 align_evt;
    endproperty
    a_evt_latency: assert property (p_evt_latency)
        else $error("alignment edge not seen three cycles after input rise");

endmodule

// ===== verilog/cds_clock_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Divide the sample clock by an integer ratio from one to eight.
// - Alignment register bits choose realign on every pulse or first after write.
// - Each accepted alignment pulse returns the divider to its initial count.
// - Alignment input passes a synchroniser on the sample clock first.
// - Stabilizer on: falling edge regenerated for a nominal half-period duty.
// - Stabilizer loop does not run below about twenty megahertz.
// - After a rate change the stabilizer is bypassed until relocked.
// - Power-down by pin or serial command puts data drivers in high impedance.
// - Power-down pin low returns the device to normal operation unless serial power-down or standby is set.
// - Power-down shuts off reference, its buffer, bias and internal clock.
// - Serial-only standby keeps the reference powered for faster wake-up.
// - Floating clock inputs: negative clock input pulled low, no spurious edges.
module cds_clock_ctrl (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        align_in,
    input  wire logic                        clk_n_float,
    input  wire logic                        power_down_pin,
    input  wire logic                        spi_power_down,
    input  wire logic                        spi_standby,
    input  wire logic                        duty_cycle_stabilizer_en,
    input  wire logic [cds_pkg::DIV_W-1:0]   div_ratio_code,
    input  wire logic                        clk_rate_changed,
    input  wire logic                        reg_wr_en,
    input  wire logic [cds_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [cds_pkg::DATA_W-1:0]  reg_wr_data,
    output logic      [cds_pkg::DATA_W-1:0]  reg_rd_data,
    output logic                             int_clk,
    output logic                             sample_tick,
    output logic                             dcs_active,
    output logic                             dcs_config_err,
    output logic                             data_drv_oe,
    output logic                             ref_en,
    output logic                             ref_buf_en,
    output logic                             bias_en,
    output logic                             clk_en,
    output logic                             clk_n_o,
    output logic                             clk_n_oe
);
    import cds_pkg::*;

    typedef struct packed {
        cds_pwr_t          pwr;
        cds_dcs_t          duty_cycle_stabilizer;
        logic [DIV_W-1:0]  div_cnt;
        logic [DIV_W-1:0]  div_code;
        logic [7:0]        relock_cnt;
        logic [DATA_W-1:0] align_ctrl;
        logic [DATA_W-1:0] rd_data;
        logic              int_clk;
        logic              tick;
        logic              drv_oe;
        logic              ref_en;
        logic              ref_buf_en;
        logic              bias_en;
        logic              clk_en;
        logic              clk_n_oe;
        logic              cfg_err;
    } cds_state_t;

    cds_state_t s_r;
    cds_state_t s_nxt;

    logic align_evt;
    logic pd_req;
    logic running;
    logic freq_change;
    logic sync_valid;
    logic ctrl_wr;
    logic rate_ok;
    logic [3:0] hi_len;

    cds_align_sync u_sync (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .align_in  (align_in),
        .align_evt (align_evt)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign pd_req      = power_down_pin | spi_power_down;
    assign running     = (s_r.pwr == PWR_RUN) && !clk_n_float;
    assign freq_change = (div_ratio_code != s_r.div_code) | clk_rate_changed;
    assign ctrl_wr     = reg_wr_en && (reg_addr == ALIGN_CTRL_ADDR);
    assign rate_ok     = (CLK_MHZ >= DCS_MIN_MHZ);
    assign sync_valid  = align_evt && s_r.align_ctrl[ALIGN_EN_BIT]
                         && (!s_r.align_ctrl[ALIGN_ONESHOT_BIT]
                             || s_r.align_ctrl[ALIGN_ARMED_BIT]);
    assign hi_len      = (s_r.duty_cycle_stabilizer == DCS_LOCKED) ? cds_half_len(s_r.div_code) : RAW_HI_LEN;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.div_code = div_ratio_code;
        s_nxt.cfg_err  = cds_dcs_needed(div_ratio_code) && !duty_cycle_stabilizer_en;

        // Power modes; pin or serial command, standby is serial only
        if (pd_req) begin
            s_nxt.pwr = PWR_DOWN;
        end else if (spi_standby) begin
            s_nxt.pwr = PWR_STANDBY;
        end else begin
            s_nxt.pwr = PWR_RUN;
        end
        s_nxt.drv_oe     = (s_nxt.pwr == PWR_RUN);
        s_nxt.ref_en     = (s_nxt.pwr != PWR_DOWN);
        s_nxt.ref_buf_en = (s_nxt.pwr == PWR_RUN);
        s_nxt.bias_en    = (s_nxt.pwr == PWR_RUN);
        s_nxt.clk_en     = (s_nxt.pwr == PWR_RUN);
        s_nxt.clk_n_oe   = clk_n_float;

        // Alignment control; a write re-arms and wins over consumption
        if (sync_valid && s_r.align_ctrl[ALIGN_ONESHOT_BIT]) begin
            s_nxt.align_ctrl[ALIGN_ARMED_BIT] = 1'b0;
        end
        if (ctrl_wr) begin
            s_nxt.align_ctrl = reg_wr_data & ALIGN_WR_MASK;
            s_nxt.align_ctrl[ALIGN_ARMED_BIT] = 1'b1;
        end
        s_nxt.rd_data = (reg_addr == ALIGN_CTRL_ADDR) ? s_r.align_ctrl : RD_ZERO;

        // Divider
        if (!running) begin
            s_nxt.div_cnt = DIV_CNT_ZERO;
            s_nxt.tick    = 1'b0;
            s_nxt.int_clk = 1'b0;
        end else begin
            if (sync_valid || s_r.div_cnt >= s_r.div_code) begin
                s_nxt.div_cnt = DIV_CNT_ZERO;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + DIV_CNT_ONE;
            end
            s_nxt.tick    = (s_nxt.div_cnt == DIV_CNT_ZERO);
            s_nxt.int_clk = ({1'b0, s_nxt.div_cnt} < hi_len);
        end

        // Duty cycle stabilizer lock tracking
        if (!duty_cycle_stabilizer_en || !rate_ok || !running) begin
            s_nxt.duty_cycle_stabilizer        = DCS_OFF;
            s_nxt.relock_cnt = CNT8_ZERO;
        end else begin
            case (s_r.duty_cycle_stabilizer)
                DCS_OFF: begin
                    s_nxt.duty_cycle_stabilizer        = DCS_RELOCK;
                    s_nxt.relock_cnt = RELOCK_LOAD;
                end
                DCS_RELOCK: begin
                    if (freq_change) begin
                        s_nxt.relock_cnt = RELOCK_LOAD;
                    end else if (s_r.relock_cnt <= RELOCK_LAST) begin
                        s_nxt.duty_cycle_stabilizer        = DCS_LOCKED;
                        s_nxt.relock_cnt = CNT8_ZERO;
                    end else begin
                        s_nxt.relock_cnt = s_r.relock_cnt - CNT8_ONE;
                    end
                end
                DCS_LOCKED: begin
                    if (freq_change) begin
                        s_nxt.duty_cycle_stabilizer        = DCS_RELOCK;
                        s_nxt.relock_cnt = RELOCK_LOAD;
                    end
                end
                default: begin
                    s_nxt.duty_cycle_stabilizer        = DCS_OFF;
                    s_nxt.relock_cnt = CNT8_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rd_data    = s_r.rd_data;
    assign int_clk        = s_r.int_clk;
    assign sample_tick    = s_r.tick;
    assign dcs_active     = (s_r.duty_cycle_stabilizer == DCS_LOCKED);
    assign dcs_config_err = s_r.cfg_err;
    assign data_drv_oe    = s_r.drv_oe;
    assign ref_en         = s_r.ref_en;
    assign ref_buf_en     = s_r.ref_buf_en;
    assign bias_en        = s_r.bias_en;
    assign clk_en         = s_r.clk_en;
    assign clk_n_o        = CLK_N_PULL_LVL;
    assign clk_n_oe       = s_r.clk_n_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] bypass_cyc;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || dcs_active || freq_change) begin
            bypass_cyc <= CNT8_ZERO;
        end else if (bypass_cyc != CNT8_MAX) begin
            bypass_cyc <= bypass_cyc + CNT8_ONE;
        end
    end

    property p_div_wrap;
        @(posedge ref_clk) disable iff (!rst_n)
        (running && s_r.div_cnt == s_r.div_code && s_r.div_code == div_ratio_code
         && s_nxt.pwr == PWR_RUN)
        |=> (s_r.div_cnt == DIV_CNT_ZERO) && sample_tick;
    endproperty
    a_div_wrap: assert property (p_div_wrap)
        else $error("divider did not wrap at the programmed ratio");

    property p_align_reset;
        @(posedge ref_clk) disable iff (!rst_n)
        (sync_valid && running && s_nxt.pwr == PWR_RUN)
        |=> (s_r.div_cnt == DIV_CNT_ZERO) && sample_tick;
    endproperty
    a_align_reset: assert property (p_align_reset)
        else $error("accepted alignment did not reset the divider");

    property p_oneshot;
        @(posedge ref_clk) disable iff (!rst_n)
        (sync_valid && s_r.align_ctrl[ALIGN_ONESHOT_BIT] && !ctrl_wr)
        |=> !s_r.align_ctrl[ALIGN_ARMED_BIT];
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot alignment stayed armed");

    property p_rewrite_arms;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_wr |=> s_r.align_ctrl[ALIGN_ARMED_BIT]
                 && s_r.align_ctrl[ALIGN_EN_BIT] == $past(reg_wr_data[ALIGN_EN_BIT]);
    endproperty
    a_rewrite_arms: assert property (p_rewrite_arms)
        else $error("register write did not arm alignment");

    property p_pd_hiz;
        @(posedge ref_clk) disable iff (!rst_n)
        pd_req |=> !data_drv_oe && !ref_en && !ref_buf_en && !bias_en && !clk_en;
    endproperty
    a_pd_hiz: assert property (p_pd_hiz)
        else $error("power-down left drivers or analog blocks on");

    property p_pd_no_tick;
        @(posedge ref_clk) disable iff (!rst_n)
        pd_req [*2] |=> !sample_tick && !int_clk;
    endproperty
    a_pd_no_tick: assert property (p_pd_no_tick)
        else $error("internal clock running in power-down");

    property p_standby;
        @(posedge ref_clk) disable iff (!rst_n)
        (!pd_req && spi_standby) |=> ref_en && !data_drv_oe && !clk_en;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby did not keep only the reference powered");

    property p_wake;
        @(posedge ref_clk) disable iff (!rst_n)
        (!pd_req && !spi_standby) |=> data_drv_oe && ref_en && clk_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("device did not return to normal operation");

    property p_relock_wait;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(dcs_active) |-> bypass_cyc >= RELOCK_LOAD;
    endproperty
    a_relock_wait: assert property (p_relock_wait)
        else $error("stabilizer locked before the relock time");

    property p_float_pull;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_n_float |=> clk_n_oe && !clk_n_o && !sample_tick;
    endproperty
    a_float_pull: assert property (p_float_pull)
        else $error("floating clock not pulled low or edges seen");

endmodule

// ===== verification/cds_sync_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Alignment pulse driver
// ------------------------------------------------------------
module cds_sync_src (
    input  wire logic ref_clk,
    output logic      align_in
);
    // Single-ended level, launched on the falling edge so it is steady at the sampling edge
    initial begin
        align_in = 1'b0;
    end

    task automatic pulse(input int hi_cyc);
        align_in = 1'b1;
        repeat (hi_cyc) @(negedge ref_clk);
        align_in = 1'b0;
    endtask
endmodule

// ===== verification/tb_clock_divider_sync_powerdown.sv
`timescale 1ns/1ps
module tb_clock_divider_sync_powerdown;
    import cds_pkg::*;

    logic              ref_clk;
    logic              rst_n;
    logic              align_in;
    logic              clk_n_float;
    logic              power_down_pin;
    logic              spi_power_down;
    logic              spi_standby;
    logic              stab_en;
    logic [DIV_W-1:0]  div_code;
    logic              rate_chg;
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              int_clk, sample_tick, dcs_active, cfg_err, drv_oe;
    logic              ref_en, ref_buf_en, bias_en, clk_en, clk_n_o, clk_n_oe;
    int                err_total;
    int                compares;
    int                cyc = 0;

    cds_clock_ctrl uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .align_in(align_in), .clk_n_float(clk_n_float),
        .power_down_pin(power_down_pin), .spi_power_down(spi_power_down),
        .spi_standby(spi_standby), .duty_cycle_stabilizer_en(stab_en),
        .div_ratio_code(div_code), .clk_rate_changed(rate_chg), .reg_wr_en(wr_en),
        .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata), .int_clk(int_clk),
        .sample_tick(sample_tick), .dcs_active(dcs_active), .dcs_config_err(cfg_err),
        .data_drv_oe(drv_oe), .ref_en(ref_en), .ref_buf_en(ref_buf_en), .bias_en(bias_en),
        .clk_en(clk_en), .clk_n_o(clk_n_o), .clk_n_oe(clk_n_oe)
    );

    cds_sync_src src (
        .ref_clk(ref_clk),
        .align_in(align_in)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and report
    // ------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Checks %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic cyc_wait(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge ref_clk);
        wr_en = 1'b0;
        addr  = ALIGN_CTRL_ADDR;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        addr = a;
        @(negedge ref_clk);
        chk("reg_rd_data", exp, {8'h00, rdata});
        addr = ALIGN_CTRL_ADDR;
    endtask

    // Ticks and high cycles over 840 cycles, a common multiple of all ratios
    task automatic meas(input int r, input int hi);
        int t, h;
        t = 0;
        h = 0;
        repeat (840) begin
            @(negedge ref_clk);
            t += (sample_tick === 1'b1);
            h += (int_clk === 1'b1);
        end
        chk("tick count", 16'(840 / r), 16'(t));
        chk("int_clk high", 16'(840 / r * hi), 16'(h));
    endtask

    // Pulse two cycles after a tick, then look where a realigned tick must land
    task automatic align_try(input logic exp);
        int n;
        n = 0;
        while (sample_tick !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        cyc_wait(2);
        src.pulse(1);
        cyc_wait(3);
        chk("aligned tick", {15'h0000, exp}, {15'h0000, sample_tick});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        rst_n = 1'b0;
        clk_n_float = 1'b0;
        power_down_pin = 1'b0;
        spi_power_down = 1'b0;
        spi_standby = 1'b0;
        stab_en = 1'b0;
        div_code = 3'h0;
        rate_chg = 1'b0;
        wr_en = 1'b0;
        addr = ALIGN_CTRL_ADDR;
        wdata = 8'h00;
        err_total = 0;
        compares = 0;
        cyc_wait(5);
        rst_n = 1'b1;
        cyc_wait(2);
        reg_rd(ALIGN_CTRL_ADDR, 16'h0000);
        chk("drv_oe", 16'h0001, {15'h0000, drv_oe});
        reg_wr(ALIGN_CTRL_ADDR, 8'h06);
        reg_rd(ALIGN_CTRL_ADDR, 16'h0007);
        reg_wr(12'h200, 8'hff);
        reg_rd(ALIGN_CTRL_ADDR, 16'h0007);
        reg_rd(12'h200, 16'h0000);

        div_code = 3'h7;
        stab_en = 1'b1;
        cyc_wait(160);
        align_try(1'b1);
        align_try(1'b0);
        reg_rd(ALIGN_CTRL_ADDR, 16'h0006);
        reg_wr(ALIGN_CTRL_ADDR, 8'h06);
        align_try(1'b1);
        reg_wr(ALIGN_CTRL_ADDR, 8'h02);
        align_try(1'b1);
        align_try(1'b1);
        reg_wr(ALIGN_CTRL_ADDR, 8'h00);
        align_try(1'b0);
        reg_wr(ALIGN_CTRL_ADDR, 8'h04);
        align_try(1'b0);

        rate_chg = 1'b1;
        cyc_wait(1);
        rate_chg = 1'b0;
        cyc_wait(3);
        chk("relock start", 16'h0000, {15'h0000, dcs_active});
        cyc_wait(160);
        chk("relocked", 16'h0001, {15'h0000, dcs_active});

        for (int c = 0; c < 8; c++) begin
            stab_en = 1'b0;
            div_code = 3'(c);
            cyc_wait(4);
            meas(c + 1, 1);
            chk("cfg err", {15'h0000, !(c == 0 || c == 1 || c == 3)}, {15'h0000, cfg_err});
            stab_en = 1'b1;
            cyc_wait(140);
            chk("lock early", 16'h0000, {15'h0000, dcs_active});
            cyc_wait(20);
            chk("locked", 16'h0001, {15'h0000, dcs_active});
            chk("cfg ok", 16'h0000, {15'h0000, cfg_err});
            meas(c + 1, (c + 2) / 2);
        end

        for (int m = 0; m < 3; m++) begin
            power_down_pin = (m == 0);
            spi_power_down = (m == 1);
            spi_standby = (m == 2);
            cyc_wait(2);
            chk("drv_oe", 16'h0000, {15'h0000, drv_oe});
            chk("ref_en", {15'h0000, m == 2}, {15'h0000, ref_en});
            chk("clk_en", 16'h0000, {15'h0000, clk_en});
            if (m < 2) begin
                chk("ref_buf_en", 16'h0000, {15'h0000, ref_buf_en});
                chk("bias_en", 16'h0000, {15'h0000, bias_en});
            end
        end
        power_down_pin = 1'b0;
        spi_standby = 1'b0;
        cyc_wait(2);
        chk("drv_oe back", 16'h0001, {15'h0000, drv_oe});
        chk("ref_buf_en back", 16'h0001, {15'h0000, ref_buf_en});
        chk("clk_en back", 16'h0001, {15'h0000, clk_en});

        clk_n_float = 1'b1;
        cyc_wait(2);
        chk("clk_n_oe", 16'h0001, {15'h0000, clk_n_oe});
        chk("clk_n_o", 16'h0000, {15'h0000, clk_n_o});
        n = 0;
        repeat (16) begin
            @(negedge ref_clk);
            n += (sample_tick === 1'b1);
        end
        chk("float ticks", 16'h0000, 16'(n));
        clk_n_float = 1'b0;
        cyc_wait(2);
        chk("clk_n_oe off", 16'h0000, {15'h0000, clk_n_oe});
        summarize();
    end
endmodule
